// ==== chc_defs.svh ====
// Offsets, field positions, reset values and scale constants of the charger register bank
`ifndef CHC_DEFS_SVH
`define CHC_DEFS_SVH

`define CHC_OFS_SWITCH_CTRL   8'h09
`define CHC_OFS_BOOST_CFG     8'h0a
`define CHC_OFS_STATE_REPORT  8'h0b

`define CHC_RST_SWITCH_CTRL   8'h44
`define CHC_RST_BOOST_CFG     8'h73
`define CHC_WDM_SWITCH_CTRL   8'hd3
`define CHC_WDM_BOOST_CFG     8'hd7

`define CHC_BIT_FORCE_START   7
`define CHC_BIT_HALF_RATE     6
`define CHC_BIT_SW_DISABLE    5
`define CHC_BIT_HOT_VSEL      4
`define CHC_BIT_OFF_DELAY     3
`define CHC_BIT_SYS_RST_EN    2
`define CHC_BIT_PULSE_UP      1
`define CHC_BIT_PULSE_DN      0

`define CHC_MSB_OTG_VCODE     7
`define CHC_LSB_OTG_VCODE     4
`define CHC_BIT_OTG_LIGHT     3
`define CHC_MSB_OTG_ILIM      2
`define CHC_LSB_OTG_ILIM      0

`define CHC_BIT_SRC_MSB       7
`define CHC_BIT_SRC_LSB       5
`define CHC_BIT_PHASE_MSB     4
`define CHC_BIT_PHASE_LSB     3
`define CHC_BIT_PGOOD         2
`define CHC_BIT_MINSYS        0

`define CHC_CHARGE_VOLTAGE_LIMIT_BASE_MV      13'd3840
`define CHC_CHARGE_VOLTAGE_LIMIT_STEP_MV      13'd16
`define CHC_HOT_DROP_MV       13'd200
`define CHC_OTG_BASE_MV       13'd4550
`define CHC_OTG_STEP_MV       13'd64

`define CHC_ILIM_0_MA         12'd500
`define CHC_ILIM_1_MA         12'd750
`define CHC_ILIM_2_MA         12'd1200
`define CHC_ILIM_3_MA         12'd1400
`define CHC_ILIM_4_MA         12'd1650
`define CHC_ILIM_5_MA         12'd1875
`define CHC_ILIM_6_MA         12'd2150
`define CHC_ILIM_7_MA         12'd2450

`endif

// ==== chc_pkg.sv ====
// Types shared by the charger register bank
package chc_pkg;
	typedef logic [7:0] chc_byte_t;
	typedef enum logic [1:0] {
		CHC_SW_ON,
		CHC_SW_WAIT,
		CHC_SW_OFF
	} chc_switch_e;
endpackage

// ==== chc_regs.sv ====
// Control, boost configuration and status registers of a single-cell charger
`timescale 1ns/1ps
`include "chc_defs.svh"

// What this block does
// R1: Writing one to force-start launches optimizer; bit sets only, clears when run starts.
// R2: Timer slowdown bit one halves safety timer rate during regulation; zero gives full rate.
// R3: Switch disable bit forces battery switch off into ship mode; a write of zero or software reset clears it, watchdog does not.
// R4: With disable set, delay bit zero opens switch at once, one waits ship delay.
// R5: Reset enable bit permits switch-driven full system reset; watchdog leaves it, software reset sets it to one.
// R6: Hot range target is limit minus 200mV when select is zero, full limit when one.
// R7: Pulse-up request accepts one only with pulse enable, clears when its sequence completes.
// R8: Pulse-down request accepts one only with pulse enable, clears when its sequence completes.
// R9: Boost voltage code in bits 7:4 sets target 4.55V plus 64mV steps; default 0111.
// R10: Light-load bit zero allows pulse-frequency boost, one forces fixed frequency; software reset only.
// R11: Boost current limit codes map to 0.5 through 2.45A; default code 011.
// R12: Status source field reports eight input source types, codes 000 through 111.
// R13: Status phase field reports idle, pre-charge, fast charge, termination done.
// R14: Power-good status bit reads one when input qualifies as power good.
// R15: Status bit 1 is reserved and always reads zero.
// R16: Minimum-system bit reads one while battery is below minimum system voltage.
// R17: Watchdog expiry is reported through a read-only fault flag.
// R18: Status reads have no side effect and show live state.
module chc_regs #(
	parameter int unsigned SHIP_DELAY_CYCLES = 1250000
) (
	input  wire logic                   core_clk,
	input  wire logic                   rstn,
	input  wire logic [7:0]             reg_addr,
	input  wire logic                   reg_wr,
	input  wire chc_pkg::chc_byte_t     reg_wdata,
	input  wire logic                   reg_rd,
	output chc_pkg::chc_byte_t          reg_rdata,
	input  wire logic                   sw_reg_reset,
	input  wire logic                   wdog_expire,
	input  wire logic                   current_pulse_enable,
	input  wire logic                   optimizer_started,
	input  wire logic                   pulse_seq_done,
	input  wire logic                   timer_tick,
	input  wire logic                   switch_reset_request,
	input  wire logic [5:0]             charge_voltage_limit,
	input  wire logic [2:0]             input_source_type,
	input  wire logic [1:0]             charge_phase,
	input  wire logic                   power_good_in,
	input  wire logic                   min_system_in,
	input  wire logic                   regulation_active,
	input  wire logic                   hot_range_active,
	output logic                        optimizer_force_start,
	output logic                        pulse_voltage_up_request,
	output logic                        pulse_voltage_down_request,
	output logic                        timer_count_tick,
	output logic                        battery_switch_on,
	output logic                        ship_mode,
	output logic                        system_reset_pulse,
	output logic [12:0]                 charge_target_mv,
	output logic [12:0]                 otg_voltage_mv,
	output logic [11:0]                 otg_current_limit_ma,
	output logic                        otg_light_load_disable,
	output logic                        watchdog_fault
);

	if (SHIP_DELAY_CYCLES < 1) begin : g_bad_delay
		$error("SHIP_DELAY_CYCLES must be at least one");
	end

	chc_pkg::chc_byte_t   optimizer_switch_control_r, optimizer_switch_control_nxt;
	chc_pkg::chc_byte_t   boost_configuration_r, boost_configuration_nxt;
	chc_pkg::chc_switch_e sw_state_r, sw_state_nxt;
	logic [31:0]          ship_cnt_r;
	logic [8:0]           sync1_r, sync2_r;
	logic                 half_phase_r;

	// Status and analog flags cross from the power stage
	wire [8:0] live_raw = {hot_range_active, regulation_active, input_source_type,
		charge_phase, power_good_in, min_system_in};
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= live_raw;
			sync2_r <= sync1_r;
		end
	end

	wire       hot_s     = sync2_r[8];
	wire       regul_s   = sync2_r[7];
	wire [2:0] src_s     = sync2_r[6:4];
	wire [1:0] phase_s   = sync2_r[3:2];
	wire       pgood_s   = sync2_r[1];
	wire       minsys_s  = sync2_r[0];

	wire wr09 = reg_wr && (reg_addr == `CHC_OFS_SWITCH_CTRL);
	wire wr0a = reg_wr && (reg_addr == `CHC_OFS_BOOST_CFG);
	wire rd09 = reg_addr == `CHC_OFS_SWITCH_CTRL;
	wire rd0a = reg_addr == `CHC_OFS_BOOST_CFG;
	wire rd0b = reg_addr == `CHC_OFS_STATE_REPORT;

	// Reserved bit 1 is tied low; fields are the live synchronised levels
	wire [7:0] status_word = {src_s, phase_s, pgood_s, 1'b0, minsys_s}; // R12 R13 R14 R15 R16

	wire [7:0] rd_mux = rd09 ? optimizer_switch_control_r :
		rd0a ? boost_configuration_r :
		rd0b ? status_word : 8'h00;

	always_comb begin
		optimizer_switch_control_nxt = optimizer_switch_control_r;
		if (wdog_expire) begin
			optimizer_switch_control_nxt = (optimizer_switch_control_r & ~`CHC_WDM_SWITCH_CTRL) |
				(`CHC_RST_SWITCH_CTRL & `CHC_WDM_SWITCH_CTRL); // R3 R5
		end
		if (optimizer_started) begin
			optimizer_switch_control_nxt[`CHC_BIT_FORCE_START] = 1'b0; // R1
		end
		if (pulse_seq_done) begin
			optimizer_switch_control_nxt[`CHC_BIT_PULSE_UP] = 1'b0; // R7
			optimizer_switch_control_nxt[`CHC_BIT_PULSE_DN] = 1'b0; // R8
		end
		if (wr09) begin
			optimizer_switch_control_nxt[6:2] = reg_wdata[6:2];
			if (reg_wdata[`CHC_BIT_FORCE_START]) begin
				optimizer_switch_control_nxt[`CHC_BIT_FORCE_START] = 1'b1; // R1
			end
			if (reg_wdata[`CHC_BIT_PULSE_UP] && current_pulse_enable) begin
				optimizer_switch_control_nxt[`CHC_BIT_PULSE_UP] = 1'b1; // R7
			end
			if (reg_wdata[`CHC_BIT_PULSE_DN] && current_pulse_enable) begin
				optimizer_switch_control_nxt[`CHC_BIT_PULSE_DN] = 1'b1; // R8
			end
		end
		if (sw_reg_reset) begin
			optimizer_switch_control_nxt = `CHC_RST_SWITCH_CTRL;
		end
	end

	always_comb begin
		boost_configuration_nxt = boost_configuration_r;
		if (wdog_expire) begin
			boost_configuration_nxt = (boost_configuration_r & ~`CHC_WDM_BOOST_CFG) |
				(`CHC_RST_BOOST_CFG & `CHC_WDM_BOOST_CFG); // R10
		end
		if (wr0a) begin
			boost_configuration_nxt = reg_wdata;
		end
		if (sw_reg_reset) begin
			boost_configuration_nxt = `CHC_RST_BOOST_CFG;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			optimizer_switch_control_r        <= `CHC_RST_SWITCH_CTRL;
			boost_configuration_r        <= `CHC_RST_BOOST_CFG;
			reg_rdata      <= 8'h00;
			watchdog_fault <= 1'b0;
		end else begin
			optimizer_switch_control_r        <= optimizer_switch_control_nxt;
			boost_configuration_r        <= boost_configuration_nxt;
			reg_rdata      <= reg_rd ? rd_mux : reg_rdata; // R18
			watchdog_fault <= wdog_expire | (watchdog_fault & ~sw_reg_reset); // R17
		end
	end

	assign optimizer_force_start      = optimizer_switch_control_r[`CHC_BIT_FORCE_START]; // R1
	assign pulse_voltage_up_request   = optimizer_switch_control_r[`CHC_BIT_PULSE_UP];
	assign pulse_voltage_down_request = optimizer_switch_control_r[`CHC_BIT_PULSE_DN];
	assign otg_light_load_disable     = boost_configuration_r[`CHC_BIT_OTG_LIGHT]; // R10

	// Safety timer tick: every other tick is dropped while slowed
	wire slow = optimizer_switch_control_r[`CHC_BIT_HALF_RATE] && regul_s;
	assign timer_count_tick = timer_tick && (!slow || half_phase_r); // R2

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			half_phase_r <= 1'b0;
		end else if (timer_tick) begin
			half_phase_r <= slow ? ~half_phase_r : 1'b0; // R2
		end
	end

	// Battery switch control with optional ship entry delay
	wire sw_dis   = optimizer_switch_control_r[`CHC_BIT_SW_DISABLE];
	wire dly_done = ship_cnt_r >= SHIP_DELAY_CYCLES - 1;

	always_comb begin
		sw_state_nxt = sw_state_r;
		case (sw_state_r)
			chc_pkg::CHC_SW_ON: begin
				if (sw_dis) begin
					sw_state_nxt = optimizer_switch_control_r[`CHC_BIT_OFF_DELAY] ? chc_pkg::CHC_SW_WAIT
						: chc_pkg::CHC_SW_OFF; // R3 R4
				end
			end
			chc_pkg::CHC_SW_WAIT: begin
				if (!sw_dis) begin
					sw_state_nxt = chc_pkg::CHC_SW_ON;
				end else if (dly_done) begin
					sw_state_nxt = chc_pkg::CHC_SW_OFF; // R4
				end
			end
			chc_pkg::CHC_SW_OFF: begin
				if (!sw_dis) begin
					sw_state_nxt = chc_pkg::CHC_SW_ON;
				end
			end
			default: sw_state_nxt = chc_pkg::CHC_SW_ON;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sw_state_r <= chc_pkg::CHC_SW_ON;
			ship_cnt_r <= '0;
		end else begin
			sw_state_r <= sw_state_nxt;
			ship_cnt_r <= (sw_state_r == chc_pkg::CHC_SW_WAIT) ? ship_cnt_r + 32'd1 : 32'd0;
		end
	end

	assign battery_switch_on = sw_state_r != chc_pkg::CHC_SW_OFF; // R3
	assign ship_mode         = sw_state_r == chc_pkg::CHC_SW_OFF;

	// Derived regulation targets
	wire [12:0] charge_voltage_limit_mv = `CHC_CHARGE_VOLTAGE_LIMIT_BASE_MV + {7'd0, charge_voltage_limit} * `CHC_CHARGE_VOLTAGE_LIMIT_STEP_MV;
	wire [12:0] hot_mv  = (hot_s && !optimizer_switch_control_r[`CHC_BIT_HOT_VSEL]) ?
		charge_voltage_limit_mv - `CHC_HOT_DROP_MV : charge_voltage_limit_mv; // R6
	wire [3:0]  vcode   = boost_configuration_r[`CHC_MSB_OTG_VCODE:`CHC_LSB_OTG_VCODE];
	wire [12:0] otg_mv  = `CHC_OTG_BASE_MV + {9'd0, vcode} * `CHC_OTG_STEP_MV; // R9
	wire [2:0]  icode   = boost_configuration_r[`CHC_MSB_OTG_ILIM:`CHC_LSB_OTG_ILIM];
	logic [11:0] ilim_ma;

	always_comb begin
		case (icode) // R11
			3'h0: ilim_ma = `CHC_ILIM_0_MA;
			3'h1: ilim_ma = `CHC_ILIM_1_MA;
			3'h2: ilim_ma = `CHC_ILIM_2_MA;
			3'h3: ilim_ma = `CHC_ILIM_3_MA;
			3'h4: ilim_ma = `CHC_ILIM_4_MA;
			3'h5: ilim_ma = `CHC_ILIM_5_MA;
			3'h6: ilim_ma = `CHC_ILIM_6_MA;
			default: ilim_ma = `CHC_ILIM_7_MA;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			charge_target_mv     <= '0;
			otg_voltage_mv       <= '0;
			otg_current_limit_ma <= '0;
			system_reset_pulse   <= 1'b0;
		end else begin
			charge_target_mv     <= hot_mv;
			otg_voltage_mv       <= otg_mv;
			otg_current_limit_ma <= ilim_ma;
			system_reset_pulse   <= switch_reset_request && optimizer_switch_control_r[`CHC_BIT_SYS_RST_EN]; // R5
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	chk_force_clear: assert property ( // R1
		optimizer_started && !wr09 && !sw_reg_reset |=> !optimizer_force_start)
		else $error("force start did not clear after optimizer start");
	chk_up_gate: assert property ( // R7
		wr09 && reg_wdata[1] && !current_pulse_enable && !optimizer_switch_control_r[1] && !sw_reg_reset
		|=> !pulse_voltage_up_request)
		else $error("pulse up accepted without pulse enable");
	chk_down_gate: assert property ( // R8
		wr09 && reg_wdata[0] && current_pulse_enable && !sw_reg_reset
		|=> pulse_voltage_down_request)
		else $error("pulse down not accepted with pulse enable");
	chk_disable_keep: assert property ( // R3
		wdog_expire && !sw_reg_reset && !wr09 && sw_dis |=> sw_dis)
		else $error("switch disable cleared by watchdog");
	chk_off_now: assert property ( // R4
		sw_state_r == chc_pkg::CHC_SW_ON && sw_dis && !optimizer_switch_control_r[3] |=> ship_mode)
		else $error("switch did not open immediately");
	chk_otg_volt: assert property ( // R9
		$stable(boost_configuration_r) |=> otg_voltage_mv == 13'd4550 + {9'd0, $past(vcode)} * 13'd64)
		else $error("boost voltage target mismatch");
	chk_rsvd_zero: assert property ( // R15
		reg_rd && rd0b |=> !reg_rdata[1])
		else $error("reserved status bit read as one");
	chk_reset_gate: assert property ( // R5
		system_reset_pulse |-> $past(optimizer_switch_control_r[2]) && $past(switch_reset_request))
		else $error("system reset while not enabled");
	chk_half_rate: assert property ( // R2
		timer_tick && slow && !half_phase_r |-> !timer_count_tick)
		else $error("slowed timer passed a dropped tick");

endmodule // chc_regs

// ==== chc_host.sv ====
// Host-side model that drives the charger register port
`timescale 1ns/1ps
module chc_host (
	input  wire logic                core_clk,
	output logic [7:0]               reg_addr,
	output logic                     reg_wr,
	output chc_pkg::chc_byte_t       reg_wdata,
	output logic                     reg_rd,
	input  wire chc_pkg::chc_byte_t  reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
		reg_rd = 1'b0;
	end
	// One-cycle strobes, launched and released at falling edges
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge core_clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge core_clk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
endmodule // chc_host

// ==== tb.sv ====
// Self-checking bench for the charger register bank
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin error_cnt++; \
	$display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module tb;
	logic               core_clk = 1'b0;
	logic               rstn;
	logic [7:0]         reg_addr;
	logic               reg_wr, reg_rd;
	chc_pkg::chc_byte_t reg_wdata, reg_rdata;
	logic               sw_reg_reset, wdog_expire, current_pulse_enable, optimizer_started;
	logic               pulse_seq_done, timer_tick, switch_reset_request;
	logic [5:0]         charge_voltage_limit;
	logic [2:0]         input_source_type;
	logic [1:0]         charge_phase;
	logic               power_good_in, min_system_in, regulation_active, hot_range_active;
	logic               optimizer_force_start, pulse_voltage_up_request, pulse_voltage_down_request;
	logic               timer_count_tick, battery_switch_on, ship_mode, system_reset_pulse;
	logic [12:0]        charge_target_mv, otg_voltage_mv;
	logic [11:0]        otg_current_limit_ma;
	logic               otg_light_load_disable, watchdog_fault;
	int                 error_cnt = 0, samples_checked = 0, seed = 32'h2968, i, n;
	logic [7:0]         v, w;

	always #4 core_clk = ~core_clk;

	chc_host host_u (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	chc_regs #(.SHIP_DELAY_CYCLES(8)) dut_u (.core_clk(core_clk), .rstn(rstn),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .sw_reg_reset(sw_reg_reset), .wdog_expire(wdog_expire),
		.current_pulse_enable(current_pulse_enable), .optimizer_started(optimizer_started),
		.pulse_seq_done(pulse_seq_done), .timer_tick(timer_tick),
		.switch_reset_request(switch_reset_request), .charge_voltage_limit(charge_voltage_limit),
		.input_source_type(input_source_type), .charge_phase(charge_phase),
		.power_good_in(power_good_in), .min_system_in(min_system_in),
		.regulation_active(regulation_active), .hot_range_active(hot_range_active),
		.optimizer_force_start(optimizer_force_start),
		.pulse_voltage_up_request(pulse_voltage_up_request),
		.pulse_voltage_down_request(pulse_voltage_down_request),
		.timer_count_tick(timer_count_tick), .battery_switch_on(battery_switch_on),
		.ship_mode(ship_mode), .system_reset_pulse(system_reset_pulse),
		.charge_target_mv(charge_target_mv), .otg_voltage_mv(otg_voltage_mv),
		.otg_current_limit_ma(otg_current_limit_ma),
		.otg_light_load_disable(otg_light_load_disable), .watchdog_fault(watchdog_fault));

	function automatic logic [11:0] ilim_ma(input int c);
		logic [11:0] t[8] = '{12'd500, 12'd750, 12'd1200, 12'd1400,
			12'd1650, 12'd1875, 12'd2150, 12'd2450};
		return t[c];
	endfunction

	task automatic finish_test;
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(negedge core_clk);
	endtask

	task automatic pulse(ref logic s);
		@(negedge core_clk);
		s = 1'b1;
		@(negedge core_clk);
		s = 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [7:0] ex, input string nm);
		logic [7:0] d;
		host_u.rd(a, d);
		`CHK(nm, ex, d)
	endtask

	// Counts passed ticks over eight base ticks
	task automatic ticks(input int ex);
		int k;
		k = 0;
		repeat (8) begin
			@(negedge core_clk);
			timer_tick = 1'b1;
			#1;
			if (timer_count_tick === 1'b1)
				k++;
			@(negedge core_clk);
			timer_tick = 1'b0;
		end
		`CHK("timer ticks", ex, k)
	endtask

	task automatic sys_rst(input int ex);
		int k;
		k = 0;
		@(negedge core_clk);
		switch_reset_request = 1'b1;
		repeat (4) begin
			@(negedge core_clk);
			switch_reset_request = 1'b0;
			if (system_reset_pulse === 1'b1)
				k++;
		end
		`CHK("system reset pulses", ex, k)
	endtask

	initial begin
		repeat (20000) @(posedge core_clk);
		error_cnt++;
		finish_test;
	end

	initial begin
		rstn = 1'b0;
		{sw_reg_reset, wdog_expire, current_pulse_enable, optimizer_started, pulse_seq_done} = '0;
		{timer_tick, switch_reset_request, charge_voltage_limit, input_source_type} = '0;
		{charge_phase, power_good_in, min_system_in, regulation_active, hot_range_active} = '0;
		cyc(4);
		rstn = 1'b1;
		rdchk(8'h09, 8'h44, "optimizer_switch_control reset");
		rdchk(8'h0a, 8'h73, "boost_configuration reset");
		rdchk(8'h3c, 8'h00, "unmapped read");
		for (i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			v[2:0] = i[2:0];
			host_u.wr(8'h0a, v);
			cyc(2);
			`CHK("otg mv", 13'd4550 + 13'd64 * v[7:4], otg_voltage_mv)
			`CHK("otg ma", ilim_ma(i), otg_current_limit_ma)
			`CHK("light load", v[3], otg_light_load_disable)
			rdchk(8'h0a, v, "boost_configuration readback");
		end
		for (i = 0; i < 8; i++) begin
			v = 8'($random(seed));
			input_source_type = i[2:0];
			charge_phase = i[1:0];
			power_good_in = v[2];
			min_system_in = v[0];
			cyc(3);
			rdchk(8'h0b, {i[2:0], i[1:0], v[2], 1'b0, v[0]}, "status");
			rdchk(8'h0b, {i[2:0], i[1:0], v[2], 1'b0, v[0]}, "status again");
		end
		host_u.wr(8'h09, 8'hc4);
		cyc(1);
		`CHK("force start set", 1'b1, optimizer_force_start)
		host_u.wr(8'h09, 8'h44);
		cyc(1);
		`CHK("force start kept", 1'b1, optimizer_force_start)
		pulse(optimizer_started);
		cyc(1);
		`CHK("force start clear", 1'b0, optimizer_force_start)
		host_u.wr(8'h09, 8'h47);
		cyc(1);
		`CHK("pulse bits refused", 2'b00, {pulse_voltage_up_request, pulse_voltage_down_request})
		current_pulse_enable = 1'b1;
		host_u.wr(8'h09, 8'h47);
		cyc(1);
		`CHK("pulse bits set", 2'b11, {pulse_voltage_up_request, pulse_voltage_down_request})
		pulse(pulse_seq_done);
		cyc(1);
		`CHK("pulse bits done", 2'b00, {pulse_voltage_up_request, pulse_voltage_down_request})
		regulation_active = 1'b1;
		cyc(3);
		ticks(4);
		host_u.wr(8'h09, 8'h04);
		ticks(8);
		w = 8'($random(seed));
		charge_voltage_limit = w[5:0];
		hot_range_active = 1'b1;
		cyc(4);
		`CHK("hot target", 13'd3840 + 13'd16 * w[5:0] - 13'd200, charge_target_mv)
		host_u.wr(8'h09, 8'h14);
		cyc(3);
		`CHK("hot target full", 13'd3840 + 13'd16 * w[5:0], charge_target_mv)
		sys_rst(1);
		host_u.wr(8'h09, 8'h10);
		sys_rst(0);
		host_u.wr(8'h09, 8'h20);
		cyc(3);
		`CHK("ship now", 2'b01, {battery_switch_on, ship_mode})
		host_u.wr(8'h09, 8'h00);
		cyc(3);
		`CHK("switch back on", 2'b10, {battery_switch_on, ship_mode})
		host_u.wr(8'h09, 8'h28);
		cyc(4);
		`CHK("ship delayed", 2'b10, {battery_switch_on, ship_mode})
		cyc(8);
		`CHK("ship after delay", 2'b01, {battery_switch_on, ship_mode})
		v = 8'($random(seed));
		w = 8'($random(seed));
		// Switch disable set so the watchdog must leave it standing
		v[5] = 1'b1;
		host_u.wr(8'h09, v);
		host_u.wr(8'h0a, w);
		pulse(wdog_expire);
		cyc(1);
		`CHK("watchdog fault", 1'b1, watchdog_fault)
		rdchk(8'h09, (v & ~8'hd3) | (8'h44 & 8'hd3), "optimizer_switch_control watchdog");
		rdchk(8'h0a, (w & ~8'hd7) | (8'h73 & 8'hd7), "boost_configuration watchdog");
		pulse(sw_reg_reset);
		cyc(1);
		`CHK("fault cleared", 1'b0, watchdog_fault)
		rdchk(8'h09, 8'h44, "optimizer_switch_control soft reset");
		rdchk(8'h0a, 8'h73, "boost_configuration soft reset");
		finish_test;
	end
endmodule // tb
